// ==== design/rxsoc_pkg.sv ====
// Constants, register map and field layout of the receive system interface
package rxsoc_pkg;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0c;
   // Control field positions
   localparam int C_DUAL = 0;
   localparam int C_BYPASS = 1;
   localparam int C_FALLING = 2;
   localparam int C_LOW_TRUE = 3;
   localparam int C_E1 = 4;
   localparam int C_ALARM_SIG_EN = 5;
   localparam int C_CODE_LO = 6;
   localparam int C_TX_REF_MREF = 8;
   localparam int C_HW_MODE = 9;
   localparam int C_PAT_LO = 10;
   localparam int C_AUTO_ONES = 13;
   localparam int CTRL_W = 14;
   localparam logic [13:0] CTRL_RST = 14'h0000;
   // Status bits, mask uses the same layout
   localparam int ST_LOS_SET = 0;
   localparam int ST_LOS_CLR = 1;
   localparam int ST_CV = 2;
   localparam int ST_REF_LOSS = 3;
   localparam logic [3:0] ST_RST = 4'h0;
   // Line codes and transmit patterns
   localparam logic [1:0] CODE_AMI = 2'h0;
   localparam logic [1:0] CODE_HDB3 = 2'h1;
   localparam logic [1:0] CODE_B8ZS = 2'h2;
   localparam logic [2:0] PAT_DATA = 3'h0;
   localparam logic [2:0] PAT_ONES = 3'h1;
   localparam logic [2:0] PAT_ZEROS = 3'h2;
   localparam logic [2:0] PAT_PRBS = 3'h3;
   localparam logic [2:0] PAT_LOOP_ACT = 3'h4;
   localparam logic [2:0] PAT_LOOP_DEACT = 3'h5;
   localparam logic [2:0] LOOP_ACT_LAST = 3'h4;
   localparam logic [2:0] LOOP_DEACT_LAST = 3'h2;
   localparam logic [19:0] LFSR_SEED = 20'hfffff;
   // Timing
   localparam int MCLK_PERIOD_NS = 40;
   localparam int REF_LOSS_NS = 2000;
   localparam int REF_LOSS_CYC_I = (REF_LOSS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [5:0] REF_LOSS_CYC = 6'(REF_LOSS_CYC_I);
   // Synchroniser lanes and decoder window depth
   localparam int SYNC_W = 7;
   localparam int DEC_DEPTH = 8;
endpackage : rxsoc_pkg

// ==== design/rxsoc_dec_if.sv ====
// Bit stream carrier between the main block and the line decoder
`timescale 1ns/10ps
interface rxsoc_dec_if;
   logic strobe;
   logic pos;
   logic neg;
   logic [1:0] code;
   logic data;
   logic cv;
   modport dec (input strobe, input pos, input neg, input code, output data, output cv);
   modport user (output strobe, output pos, output neg, output code, input data, input cv);
endinterface : rxsoc_dec_if

// ==== design/rxsoc_sync.sv ====
// Two flip-flop synchroniser for all inputs from outside the clock domain
`timescale 1ns/10ps
module rxsoc_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Lanes
   input wire logic [rxsoc_pkg::SYNC_W-1:0] din,
   output logic [rxsoc_pkg::SYNC_W-1:0] dout
);
   typedef struct packed {
      logic [rxsoc_pkg::SYNC_W-1:0] s1;
      logic [rxsoc_pkg::SYNC_W-1:0] s2;
   } rxsoc_sync_s;
   rxsoc_sync_s q;
   rxsoc_sync_s d;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule : rxsoc_sync

// ==== design/rxsoc_decoder.sv ====
// AMI, HDB3 and B8ZS decoder with violation flag, eight bit latency
`timescale 1ns/10ps
module rxsoc_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Bit stream
   rxsoc_dec_if.dec bus
);
   typedef struct packed {
      logic [rxsoc_pkg::DEC_DEPTH-1:0] mark;
      logic [rxsoc_pkg::DEC_DEPTH-1:0] viol;
      logic last_pol;
      logic have_last;
      logic data;
      logic cv;
   } rxsoc_dec_s;
   rxsoc_dec_s q;
   rxsoc_dec_s d;
   logic mk;
   logic vi;

   always_comb begin
      d = q;
      mk = bus.pos | bus.neg;
      vi = (bus.pos & bus.neg) | (mk & q.have_last & (bus.pos == q.last_pol));
      if (bus.strobe) begin
         // Oldest window entry leaves; substitutions are removed before it gets there
         d.data = q.mark[rxsoc_pkg::DEC_DEPTH-1];
         d.cv = q.viol[rxsoc_pkg::DEC_DEPTH-1];
         d.mark = {q.mark[rxsoc_pkg::DEC_DEPTH-2:0], mk};
         d.viol = {q.viol[rxsoc_pkg::DEC_DEPTH-2:0], vi};
         if (mk) begin
            d.last_pol = bus.pos;
            d.have_last = 1'b1;
         end
         if (bus.code == rxsoc_pkg::CODE_HDB3 && d.viol[0] && !d.mark[1] && !d.mark[2]) begin
            for (int i = 0; i < 4; i++) begin
               d.mark[i] = 1'b0;
               d.viol[i] = 1'b0;
            end
         end
         if (bus.code == rxsoc_pkg::CODE_B8ZS && d.mark[0] && d.viol[1] && !d.mark[2] && d.mark[3] &&
             d.viol[4] && !d.mark[5] && !d.mark[6] && !d.mark[7]) begin
            d.mark = '0;
            d.viol = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.data = q.data;
   assign bus.cv = q.cv;
endmodule : rxsoc_decoder

// ==== design/rxsoc_top.sv ====
// Receive system interface, receive clock selection and transmit reference timing
//
// Contract
// - Dual rail with recovery: re-timed NRZ outputs
// - Dual rail bypassed: raw slicer data passed straight
// - Data updates on selectable receive clock edge
// - Data output active level selectable
// - Receive clock rate follows T1 or E1 source
// - Loss of signal plus enable: clock from reference
// - Recovery mode: clock is recovered line clock
// - Bypass mode: clock is slicer pos XOR neg
// - Reference selected: patterns timed by reference
// - Auto all-ones and alarm always reference timed
// - Hardware mode: all-ones and PRBS reference timed
// - Reference lost: transmit outputs high impedance
// - Loss indicator high on lost signal
// - Loss indicator clears itself on recovery
// - Single rail: NRZ decoded by line code
// - Violation flag high one full clock
`timescale 1ns/10ps
module rxsoc_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic IRQ,
   // Receive line side
   input wire logic RX_REC_CLK,
   input wire logic RX_SLICE_POS,
   input wire logic RX_SLICE_NEG,
   input wire logic LOS_DETECT,
   // Reference and transmit side inputs
   input wire logic MREF_CLK,
   input wire logic TX_CLK,
   input wire logic TX_DATA,
   // Receive system outputs
   output logic RX_LINE_CLOCK,
   output logic [1:0] RX_POS_NEG_DATA,
   output logic RX_SINGLE_RAIL_DATA,
   output logic CODE_VIOLATION_FLAG,
   output logic SIGNAL_LOSS_INDICATOR,
   // Transmit line
   output logic [1:0] TX_LINE_OUTPUTS,
   output logic TX_LINE_OE
);
   typedef struct packed {
      logic [rxsoc_pkg::CTRL_W-1:0] ctrl;
      logic [3:0] status;
      logic [3:0] mask;
      logic [31:0] rdata;
      logic irq;
      logic rclk;
      logic sel_mref;
      logic rec_prev;
      logic [1:0] pn_hold;
      logic [1:0] pn_out;
      logic sr_out;
      logic cv_out;
      logic los_out;
      logic dec_strobe;
      logic dec_pos;
      logic dec_neg;
      logic mref_prev;
      logic [5:0] ref_cnt;
      logic ref_lost;
      logic txc_prev;
      logic [19:0] lfsr;
      logic [2:0] loop_cnt;
      logic ami_pol;
      logic [1:0] tx_out;
      logic tx_oe;
   } rxsoc_top_s;
   rxsoc_top_s q;
   rxsoc_top_s d;

   logic [rxsoc_pkg::SYNC_W-1:0] sync_out;
   logic s_rec;
   logic s_pos;
   logic s_neg;
   logic s_los;
   logic s_mref;
   logic s_txc;
   logic s_txd;
   logic byp;
   logic dual;
   logic low_true;
   logic want_mref;
   logic src_line;
   logic new_src;
   logic act;
   logic rec_rise;
   logic [3:0] st_set;
   logic [3:0] st_clr;
   logic auto_ones;
   logic tx_use_mref;
   logic tclk;
   logic tick;
   logic tx_bit;
   logic fb;
   logic [2:0] pat;

   rxsoc_dec_if dif ();

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and decoder

   rxsoc_sync u_sync (
      .clk (MCLK),
      .arst_n (ARST_N),
      .din ({RX_REC_CLK, RX_SLICE_POS, RX_SLICE_NEG, LOS_DETECT, MREF_CLK, TX_CLK, TX_DATA}),
      .dout (sync_out)
   );

   assign {s_rec, s_pos, s_neg, s_los, s_mref, s_txc, s_txd} = sync_out;

   rxsoc_decoder u_dec (
      .clk (MCLK),
      .arst_n (ARST_N),
      .bus (dif.dec)
   );

   assign dif.strobe = q.dec_strobe;
   assign dif.pos = q.dec_pos;
   assign dif.neg = q.dec_neg;
   assign dif.code = q.ctrl[rxsoc_pkg::C_CODE_LO +: 2];

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      byp = q.ctrl[rxsoc_pkg::C_BYPASS];
      dual = q.ctrl[rxsoc_pkg::C_DUAL];
      low_true = q.ctrl[rxsoc_pkg::C_LOW_TRUE];
      pat = q.ctrl[rxsoc_pkg::C_PAT_LO +: 3];

      // Register writes and reads
      st_clr = 4'h0;
      if (REG_WR) begin
         case (REG_ADDR)
            rxsoc_pkg::OFS_CTRL: begin
               d.ctrl = REG_WDATA[rxsoc_pkg::CTRL_W-1:0];
            end
            rxsoc_pkg::OFS_MASK: begin
               d.mask = REG_WDATA[3:0];
            end
            rxsoc_pkg::OFS_STATUS: begin
               st_clr = REG_WDATA[3:0];
            end
            default: begin
            end
         endcase
      end
      d.rdata = 32'h0;
      if (REG_RD) begin
         case (REG_ADDR)
            rxsoc_pkg::OFS_CTRL: d.rdata = {18'h0, q.ctrl};
            rxsoc_pkg::OFS_STATUS: d.rdata = {28'h0, q.status};
            rxsoc_pkg::OFS_MASK: d.rdata = {28'h0, q.mask};
            rxsoc_pkg::OFS_STATE: d.rdata = {28'h0, q.tx_oe, q.sel_mref, q.ref_lost, q.los_out};
            default: d.rdata = 32'h0;
         endcase
      end

      // Loss indicator simply follows the detector, so it clears without software
      d.los_out = s_los;

      // Receive clock source; rate is that of the recovered line clock, the slicer pos XOR neg in bypass, or the reference clock
      want_mref = s_los & q.ctrl[rxsoc_pkg::C_ALARM_SIG_EN];
      src_line = byp ? (s_pos ^ s_neg) : s_rec;
      new_src = want_mref ? s_mref : src_line;
      // Switch only while output and new source are both low, so no short pulse appears
      if (want_mref != q.sel_mref && !q.rclk && !new_src) begin
         d.sel_mref = want_mref;
      end
      d.rclk = d.sel_mref ? s_mref : src_line;
      act = q.ctrl[rxsoc_pkg::C_FALLING] ? (q.rclk & !d.rclk) : (!q.rclk & d.rclk);

      // Recovered bit sampling feeds the re-timer and the decoder
      rec_rise = s_rec & !q.rec_prev;
      d.rec_prev = s_rec;
      d.dec_strobe = rec_rise & !byp;
      d.dec_pos = s_pos;
      d.dec_neg = s_neg;
      if (rec_rise) begin
         d.pn_hold = {s_pos, s_neg};
      end

      // Data outputs
      if (dual) begin
         d.sr_out = 1'b0;
         d.cv_out = 1'b0;
         if (byp) begin
            d.pn_out = {s_pos, s_neg} ^ {2{low_true}};
         end else if (act) begin
            d.pn_out = q.pn_hold ^ {2{low_true}};
         end
      end else begin
         d.pn_out = 2'h0;
         if (act) begin
            // Held from one active edge to the next, a full clock cycle
            d.sr_out = dif.data ^ low_true;
            d.cv_out = dif.cv;
         end
      end

      // Reference clock watchdog; a stuck reference means no transmit timing
      if (s_mref ^ q.mref_prev) begin
         d.ref_cnt = 6'h00;
      end else if (q.ref_cnt != rxsoc_pkg::REF_LOSS_CYC) begin
         d.ref_cnt = q.ref_cnt + 6'h01;
      end
      d.mref_prev = s_mref;
      d.ref_lost = (d.ref_cnt == rxsoc_pkg::REF_LOSS_CYC);
      d.tx_oe = !d.ref_lost;

      // Transmit timing source
      auto_ones = q.ctrl[rxsoc_pkg::C_AUTO_ONES] & s_los;
      tx_use_mref = q.ctrl[rxsoc_pkg::C_TX_REF_MREF] | auto_ones |
                    (q.ctrl[rxsoc_pkg::C_HW_MODE] & (pat == rxsoc_pkg::PAT_ONES || pat == rxsoc_pkg::PAT_PRBS));
      tclk = tx_use_mref ? s_mref : s_txc;
      d.txc_prev = tclk;
      tick = tclk & !q.txc_prev;

      // Pattern bit; PRBS 2^15-1 in E1, QRSS 2^20-1 otherwise
      fb = q.ctrl[rxsoc_pkg::C_E1] ? (q.lfsr[14] ^ q.lfsr[13]) : (q.lfsr[19] ^ q.lfsr[16]);
      case (pat)
         rxsoc_pkg::PAT_DATA: tx_bit = s_txd;
         rxsoc_pkg::PAT_ONES: tx_bit = 1'b1;
         rxsoc_pkg::PAT_ZEROS: tx_bit = 1'b0;
         rxsoc_pkg::PAT_PRBS: tx_bit = fb;
         rxsoc_pkg::PAT_LOOP_ACT: tx_bit = (q.loop_cnt == rxsoc_pkg::LOOP_ACT_LAST);
         rxsoc_pkg::PAT_LOOP_DEACT: tx_bit = (q.loop_cnt == rxsoc_pkg::LOOP_DEACT_LAST);
         default: tx_bit = s_txd;
      endcase
      if (auto_ones) begin
         tx_bit = 1'b1;
      end
      if (tick) begin
         d.lfsr = {q.lfsr[18:0], fb};
         if ((pat == rxsoc_pkg::PAT_LOOP_ACT && q.loop_cnt == rxsoc_pkg::LOOP_ACT_LAST) ||
             (pat == rxsoc_pkg::PAT_LOOP_DEACT && q.loop_cnt == rxsoc_pkg::LOOP_DEACT_LAST)) begin
            d.loop_cnt = 3'h0;
         end else begin
            d.loop_cnt = q.loop_cnt + 3'h1;
         end
         // Alternate mark inversion on the line
         if (tx_bit) begin
            d.tx_out = q.ami_pol ? 2'h1 : 2'h2;
            d.ami_pol = !q.ami_pol;
         end else begin
            d.tx_out = 2'h0;
         end
      end
      if (d.ref_lost) begin
         d.tx_out = 2'h0;
      end

      // Sticky events, a new event wins over a clear in the same cycle
      st_set = 4'h0;
      st_set[rxsoc_pkg::ST_LOS_SET] = s_los & !q.los_out;
      st_set[rxsoc_pkg::ST_LOS_CLR] = !s_los & q.los_out;
      st_set[rxsoc_pkg::ST_CV] = act & !dual & dif.cv;
      st_set[rxsoc_pkg::ST_REF_LOSS] = d.ref_lost & !q.ref_lost;
      d.status = (q.status & ~st_clr) | st_set;
      d.irq = |(d.status & d.mask);
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q <= '{ctrl: rxsoc_pkg::CTRL_RST, status: rxsoc_pkg::ST_RST, lfsr: rxsoc_pkg::LFSR_SEED, default: '0};
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign REG_RDATA = q.rdata;
   assign IRQ = q.irq;
   assign RX_LINE_CLOCK = q.rclk;
   assign RX_POS_NEG_DATA = q.pn_out;
   assign RX_SINGLE_RAIL_DATA = q.sr_out;
   assign CODE_VIOLATION_FLAG = q.cv_out;
   assign SIGNAL_LOSS_INDICATOR = q.los_out;
   assign TX_LINE_OUTPUTS = q.tx_out;
   assign TX_LINE_OE = q.tx_oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!ARST_N);

   a_los_follow: assert property (##1 SIGNAL_LOSS_INDICATOR == $past(s_los))
      else $error("loss indicator does not follow detector");
   a_los_selfclr: assert property (!s_los ##1 !s_los |-> ##1 !SIGNAL_LOSS_INDICATOR)
      else $error("loss indicator stays high after recovery");
   a_clk_from_ref: assert property (q.sel_mref && $past(q.sel_mref) |-> RX_LINE_CLOCK == $past(s_mref))
      else $error("substituted clock not taken from reference");
   a_clk_xor: assert property (!q.sel_mref && $past(byp) && $past(!d.sel_mref) |->
                               RX_LINE_CLOCK == $past(s_pos ^ s_neg))
      else $error("bypass clock is not slicer xor");
   a_clk_recov: assert property (!q.sel_mref && $past(!byp) && $past(!d.sel_mref) |->
                                 RX_LINE_CLOCK == $past(s_rec))
      else $error("clock is not the recovered clock");
   a_no_runt: assert property ($changed(q.sel_mref) |-> !RX_LINE_CLOCK && !$past(RX_LINE_CLOCK))
      else $error("clock switched while high");
   a_edge_only: assert property ($changed(RX_POS_NEG_DATA) && $past(dual && !byp) && $stable(q.ctrl) |->
                                 $past(act))
      else $error("retimed data changed off the active edge");
   a_raw_level: assert property ($past(dual && byp) && $stable(q.ctrl) |->
                                 RX_POS_NEG_DATA == ($past({s_pos, s_neg}) ^ {2{low_true}}))
      else $error("bypass data not raw slicer data at chosen level");
   a_cv_hold: assert property ($rose(CODE_VIOLATION_FLAG) |-> CODE_VIOLATION_FLAG [*2])
      else $error("violation flag shorter than a clock cycle");
   a_tx_hiz: assert property (q.ref_lost |-> !TX_LINE_OE && TX_LINE_OUTPUTS == 2'h0)
      else $error("transmit line driven without reference");
   a_ref_timeout: assert property ($stable(s_mref) [*8] |-> ##[0:60] q.ref_lost || $changed(s_mref))
      else $error("stuck reference not flagged");
   a_irq_level: assert property (##1 IRQ == $past(|(d.status & d.mask)))
      else $error("interrupt not tracking masked status");
endmodule : rxsoc_top

// ==== sim/rxsoc_line_src.sv ====
// Line side source model: recovered clock and slicer results
`timescale 1ns/10ps
module rxsoc_line_src (
   // Control from the bench
   input wire logic run,
   input wire logic [1:0] pat,
   // Line outputs
   output logic rec_clk,
   output logic pos,
   output logic neg
);
   logic ph;
   initial begin
      rec_clk = 1'b0;
      ph = 1'b0;
   end
   ////////////////////////////////////////
   // Clock parks low between bursts, as a recovery loop with no input would
   always #160 if (run || rec_clk) rec_clk = ~rec_clk;
   // Marks alternate only while pattern 1 runs, so a one-bit pattern 2 makes exactly one violation
   always @(negedge rec_clk) if (pat == 2'h1) ph <= ~ph;
   always_comb begin
      case (pat)
         2'h0: {pos, neg} = 2'b00;
         2'h1: {pos, neg} = {ph, ~ph};
         2'h2: {pos, neg} = 2'b10;
         default: {pos, neg} = 2'b11;
      endcase
   end
endmodule : rxsoc_line_src

// ==== sim/rxsoc_top_test.sv ====
// Self-checking bench of the receive system interface
`timescale 1ns/10ps
module rxsoc_top_test;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic los = 1'b0;
   logic mref = 1'b0;
   logic mref_run = 1'b1;
   logic tx_clk = 1'b0;
   logic tx_run = 1'b1;
   logic run = 1'b0;
   logic fall_sel = 1'b0;
   logic [1:0] pat = 2'h0;
   logic [31:0] rdata;
   logic irq, rec_clk, spos, sneg, line_clk, sr_data, cv, loss, tx_oe;
   logic [1:0] pn_data, tx_out;
   int n_errors = 0;
   int checked = 0;
   int n_out, n_ref, n_chg, n_bad, n_cv, n_tx, min_run;
   ////////////////////////////////////////
   always #20 mclk = ~mclk;
   // Reference at the E1 rate; it stops only when a scenario removes it
   always #244 if (mref_run || mref) mref = ~mref;
   always #324 if (tx_run || tx_clk) tx_clk = ~tx_clk;
   rxsoc_top i_rxsoc_top (
      .MCLK(mclk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata), .IRQ(irq), .RX_REC_CLK(rec_clk), .RX_SLICE_POS(spos), .RX_SLICE_NEG(sneg),
      .LOS_DETECT(los), .MREF_CLK(mref), .TX_CLK(tx_clk), .TX_DATA(1'b0), .RX_LINE_CLOCK(line_clk),
      .RX_POS_NEG_DATA(pn_data), .RX_SINGLE_RAIL_DATA(sr_data), .CODE_VIOLATION_FLAG(cv),
      .SIGNAL_LOSS_INDICATOR(loss), .TX_LINE_OUTPUTS(tx_out), .TX_LINE_OE(tx_oe)
   );
   rxsoc_line_src i_rxsoc_line_src (.run(run), .pat(pat), .rec_clk(rec_clk), .pos(spos), .neg(sneg));
   ////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd_chk
   // One pass gathers edge counts, shortest clock level, data moves and transmit activity
   task automatic meas(input int n, input logic use_ref);
      logic pc, pr, c, r;
      logic [1:0] pd, ptx;
      int len;
      @(posedge mclk);
      #1;
      pc = line_clk;
      pr = use_ref ? mref : rec_clk;
      pd = pn_data;
      ptx = tx_out;
      len = 99;
      min_run = 99;
      n_out = 0;
      n_ref = 0;
      n_chg = 0;
      n_bad = 0;
      n_cv = 0;
      n_tx = 0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         c = line_clk;
         r = use_ref ? mref : rec_clk;
         len++;
         if (c && !pc) n_out++;
         if (r && !pr) n_ref++;
         if (c !== pc) begin
            if (len < min_run) min_run = len;
            len = 0;
         end
         if (pn_data !== pd) begin
            n_chg++;
            if (fall_sel ? (c || !pc) : (!c || pc)) n_bad++;
         end
         if (cv === 1'b1) n_cv++;
         if (tx_out !== ptx) n_tx++;
         pc = c;
         pr = r;
         pd = pn_data;
         ptx = tx_out;
      end
   endtask : meas
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////
   initial begin
      #(20000 * 40);
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      rd_chk("ctrl", rxsoc_pkg::OFS_CTRL, 32'h0);
      rd_chk("status", rxsoc_pkg::OFS_STATUS, 32'h0);
      rd_chk("mask", rxsoc_pkg::OFS_MASK, 32'h0);
      rd_chk("state", rxsoc_pkg::OFS_STATE, 32'h8);
      rd_chk("unmapped", 8'h10, 32'h0);
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'hffffffff);
      rd_chk("ctrl", rxsoc_pkg::OFS_CTRL, 32'h3fff);
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'h0);
      wr_reg(rxsoc_pkg::OFS_STATUS, 32'hf);
      los <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk("loss", 1, loss);
      chk("irq masked", 0, irq);
      wr_reg(rxsoc_pkg::OFS_MASK, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq", 1, irq);
      @(posedge mclk);
      los <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      chk("loss", 0, loss);
      rd_chk("status", rxsoc_pkg::OFS_STATUS, 32'h3);
      wr_reg(rxsoc_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq cleared", 0, irq);
      rd_chk("status", rxsoc_pkg::OFS_STATUS, 32'h2);
      run <= 1'b1;
      pat <= 2'h1;
      meas(400, 1'b0);
      chk("rate", 1, n_out + 1 >= n_ref && n_out <= n_ref + 1);
      run <= 1'b0;
      @(posedge mclk);
      los <= 1'b1;
      repeat (10) @(posedge mclk);
      meas(100, 1'b1);
      chk("clk stopped", 0, n_out);
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'h20);
      repeat (20) @(posedge mclk);
      meas(400, 1'b1);
      chk("clk on ref", 1, n_out > 20 && n_out + 1 >= n_ref && n_out <= n_ref + 1);
      chk("no runt", 1, min_run >= 3);
      rd_chk("state", rxsoc_pkg::OFS_STATE, 32'hd);
      los <= 1'b0;
      // Let the clock fall back to the parked recovered clock before the slicer is held high
      repeat (20) @(posedge mclk);
      // Bypass: static slicer levels, with and without inverted data
      for (int k = 0; k < 4; k++) begin
         pat <= k[0] ? 2'h3 : 2'h2;
         wr_reg(rxsoc_pkg::OFS_CTRL, k[1] ? 32'hb : 32'h3);
         repeat (6) @(posedge mclk);
         #1;
         chk("bypass clk", !k[0], line_clk);
         chk("bypass data", {1'b1, k[0]} ^ {2{k[1]}}, pn_data);
      end
      pat <= 2'h1;
      run <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         fall_sel <= k[0];
         wr_reg(rxsoc_pkg::OFS_CTRL, k[0] ? 32'h5 : 32'h1);
         repeat (20) @(posedge mclk);
         meas(200, 1'b0);
         chk("edge", 0, n_bad);
         chk("data moves", 1, n_chg > 10);
         chk("nrz", 1, pn_data === 2'b10 || pn_data === 2'b01);
      end
      fall_sel <= 1'b0;
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'h0);
      repeat (200) @(posedge mclk);
      #1;
      chk("decoded", 1, sr_data);
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'h8);
      repeat (24) @(posedge mclk);
      #1;
      chk("low true", 0, sr_data);
      wr_reg(rxsoc_pkg::OFS_CTRL, 32'h0);
      wr_reg(rxsoc_pkg::OFS_STATUS, 32'hf);
      @(posedge rec_clk);
      pat <= 2'h2;
      @(posedge rec_clk);
      pat <= 2'h1;
      meas(200, 1'b0);
      chk("cv length", 1, n_cv >= 7 && n_cv <= 9);
      rd_chk("status cv", rxsoc_pkg::OFS_STATUS, 32'h4);
      // Transmit clock halted: any line activity must come from the reference
      run <= 1'b0;
      tx_run <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         wr_reg(rxsoc_pkg::OFS_CTRL, k == 0 ? 32'h500 : k == 1 ? 32'h600 : 32'h2000);
         los <= (k == 2);
         repeat (10) @(posedge mclk);
         meas(100, 1'b1);
         chk("tx on ref", 1, n_tx > 2);
      end
      mref_run <= 1'b0;
      wr_reg(rxsoc_pkg::OFS_MASK, 32'h8);
      repeat (80) @(posedge mclk);
      #1;
      chk("tx oe", 0, tx_oe);
      chk("tx out", 0, tx_out);
      chk("irq ref", 1, irq);
      rd_chk("state", rxsoc_pkg::OFS_STATE, 32'h3);
      wrap_up();
   end
endmodule : rxsoc_top_test
